// ### ldc_pkg.sv
// Package of the load-side bank-conflict and miss-tracking controller.
// Assumes a byte address of ADDR_W bits and a single core clock.
package ldc_pkg;

  localparam int ADDR_W      = 40;
  localparam int LINE_BYTES  = 64;
  localparam int LINE_LSB    = 6;
  localparam int BANK_LSB    = 4;
  localparam int BANK_MSB    = 6;
  localparam int ROW_LSB     = 7;
  localparam int ROW_MSB     = 11;
  localparam int N_BANKS     = 8;
  localparam int BANK_BYTES  = 16;
  localparam int N_MISS      = 8;
  localparam int N_STQ       = 4;
  localparam int WC_DATA_W   = LINE_BYTES * 8;
  localparam int LINE_W      = ADDR_W - LINE_LSB;

  typedef struct packed {
    logic              vld;
    logic [ADDR_W-1:0] addr;
  } ldc_req_t;

  typedef struct packed {
    logic              vld;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        data;
  } ldc_st_t;

  typedef struct packed {
    logic              vld;
    logic [LINE_W-1:0] line;
    logic              pref;
  } ldc_mem_t;

  typedef struct packed {
    logic                  vld;
    logic [LINE_W-1:0]     line;
    logic [LINE_BYTES-1:0] be;
    logic [WC_DATA_W-1:0]  data;
  } ldc_wc_t;

endpackage

// ### ldc_bank_ram.sv
// Eight-bank data array with a registered 16-byte read slice per bank.
// Assumes the controller never issues two reads to one bank with different rows.
`timescale 1ns/1ps
module ldc_bank_ram #(
  parameter int ROWS_W = 5
) (
  // Clock.
  input  wire logic                                           clock,
  // Per-bank read port.
  input  wire logic [ldc_pkg::N_BANKS-1:0]                    rd_en,
  input  wire logic [ldc_pkg::N_BANKS-1:0][ROWS_W-1:0]        rd_row,
  output logic      [ldc_pkg::N_BANKS-1:0][ldc_pkg::BANK_BYTES*8-1:0] rd_data,
  // Per-bank fill port.
  input  wire logic [ldc_pkg::N_BANKS-1:0]                    wr_en,
  input  wire logic [ROWS_W-1:0]                              wr_row,
  input  wire logic [ldc_pkg::BANK_BYTES*8-1:0]               wr_data
);

  logic [ldc_pkg::BANK_BYTES*8-1:0] mem [ldc_pkg::N_BANKS][2**ROWS_W];

  // One process owns the whole read register, so no slice has a second driver.
  always_ff @(posedge clock)
  begin
    for (int b = 0; b < ldc_pkg::N_BANKS; b++)
    begin
      if (wr_en[b])
      begin
        mem[b][wr_row] <= wr_data;
      end
      if (rd_en[b])
      begin
        rd_data[b] <= mem[b][rd_row[b]];
      end
    end
  end

endmodule

// ### ldc_ctrl.sv
// Load pairing, miss tracking, prefetch hold and write combining for the L1 data cache.
// Assumes the load pipeline holds a request until its accept pulse and fills return by line.
// Operation
// - Data array is eight banks, each sixteen bytes wide per access.
// - Different banks never conflict, regardless of row.
// - Same bank and same row do not conflict; access is shared.
// - Conflict only on same bank, different row; only those fields compared.
// - Two loads complete without conflict unless the younger needs a new line, one load with conflict.
// - Loads served in program order; only adjacent loads pair.
// - At most eight outstanding line requests, all distinct lines.
// - Requests to an already pending line merge without a new entry.
// - Prefetch matching a pending store waits until the store is written.
// - Byte writes in one 64-byte region merge into one buffer.
// - Lines are 64 bytes for allocation and miss tracking.
// - With all entries busy a read stalls until one frees, in order.
`timescale 1ns/1ps
module ldc_ctrl #(
  parameter int ROWS_W = ldc_pkg::ROW_MSB - ldc_pkg::ROW_LSB + 1
) (
  // Clock and reset.
  input  wire logic                      clock,
  input  wire logic                      arst_n,
  // Load pair from the pipeline, older in slot 0.
  input  wire ldc_pkg::ldc_req_t         ld0,
  input  wire ldc_pkg::ldc_req_t         ld1,
  input  wire logic [1:0]                ld_hit,
  output logic [1:0]                     ld_acc_q,
  output logic                           ld_conflict_q,
  output logic [1:0][127:0]              ld_data,
  // Prefetch request and pending store state.
  input  wire ldc_pkg::ldc_req_t         pf,
  output logic                           pf_acc_q,
  input  wire ldc_pkg::ldc_st_t          st,
  input  wire logic                      st_done,
  // Line requests to memory and their release.
  output ldc_pkg::ldc_mem_t              mem_req_q,
  input  wire logic                      mem_fill,
  input  wire logic [ldc_pkg::LINE_W-1:0] mem_fill_line,
  input  wire logic [127:0]              mem_fill_data,
  input  wire logic [ldc_pkg::N_BANKS-1:0] mem_fill_bank,
  output logic [3:0]                     miss_cnt_q,
  // Write-combining input and output.
  input  wire ldc_pkg::ldc_req_t         wr,
  input  wire logic [7:0]                wr_data,
  input  wire logic                      wc_flush,
  output ldc_pkg::ldc_wc_t               wc_out_q
);

  function automatic logic [2:0] bank_of(input logic [ldc_pkg::ADDR_W-1:0] a);
    return a[ldc_pkg::BANK_MSB:ldc_pkg::BANK_LSB];
  endfunction

  function automatic logic [ROWS_W-1:0] row_of(input logic [ldc_pkg::ADDR_W-1:0] a);
    return a[ldc_pkg::ROW_LSB +: ROWS_W];
  endfunction

  function automatic logic [ldc_pkg::LINE_W-1:0] line_of(input logic [ldc_pkg::ADDR_W-1:0] a);
    return a[ldc_pkg::ADDR_W-1:ldc_pkg::LINE_LSB];
  endfunction

  // Miss table state.
  logic [ldc_pkg::N_MISS-1:0]                     mv_q, mv_d;
  logic [ldc_pkg::N_MISS-1:0][ldc_pkg::LINE_W-1:0] ml_q, ml_d;
  ldc_pkg::ldc_mem_t                              mreq_d;
  logic [3:0]                                     mcnt_d;
  logic [1:0]                                     acc_d;
  logic                                           conf_d;
  logic                                           pf_acc_d;
  logic [ldc_pkg::N_BANKS-1:0]                    rd_en;
  logic [ldc_pkg::N_BANKS-1:0][ROWS_W-1:0]        rd_row;
  logic [ldc_pkg::N_BANKS-1:0][127:0]             rd_data;
  logic [1:0][2:0]                                bank_q;
  logic [1:0][2:0]                                bank_d;

  // Write-combining state.
  ldc_pkg::ldc_wc_t wcb_q, wcb_d, wco_d;

  ldc_bank_ram #(
    .ROWS_W (ROWS_W)
  ) u_ram (
    .clock   (clock),
    .rd_en   (rd_en),
    .rd_row  (rd_row),
    .rd_data (rd_data),
    .wr_en   (mem_fill ? mem_fill_bank : '0),
    .wr_row  (mem_fill_line[ROWS_W:1]),
    .wr_data (mem_fill_data)
  );

  // Both loads read the data array from the banks they name.
  assign ld_data[0] = rd_data[bank_q[0]];
  assign ld_data[1] = rd_data[bank_q[1]];

  function automatic logic line_pending(
    input logic [ldc_pkg::N_MISS-1:0]                      v,
    input logic [ldc_pkg::N_MISS-1:0][ldc_pkg::LINE_W-1:0] l,
    input logic [ldc_pkg::LINE_W-1:0]                      x
  );
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < ldc_pkg::N_MISS; i++)
    begin
      if (v[i] && l[i] == x)
      begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction

  // Only one new line request leaves per cycle, so only the older load may allocate and
  // a younger load that needs a new line waits; this keeps the table in program order.
  always_comb
  begin
    logic       conf;
    logic       need0, need1, pf_need, free, pf_blk;
    logic [2:0] slot;
    conf     = 1'b0;
    need0    = 1'b0;
    need1    = 1'b0;
    pf_need  = 1'b0;
    free     = 1'b0;
    pf_blk   = 1'b0;
    slot     = '0;
    mv_d     = mv_q;
    ml_d     = ml_q;
    mreq_d   = '0;
    acc_d    = 2'b00;
    pf_acc_d = 1'b0;
    rd_en    = '0;
    rd_row   = '0;
    bank_d   = bank_q;
    if (mem_fill)
    begin
      for (int i = 0; i < ldc_pkg::N_MISS; i++)
      begin
        if (mv_q[i] && ml_q[i] == mem_fill_line)
        begin
          mv_d[i] = 1'b0;
        end
      end
    end
    for (int i = ldc_pkg::N_MISS - 1; i >= 0; i--)
    begin
      if (!mv_d[i])
      begin
        free = 1'b1;
        slot = 3'(i);
      end
    end
    if (ld0.vld && ld1.vld && bank_of(ld0.addr) == bank_of(ld1.addr))
    begin
      conf = row_of(ld0.addr) != row_of(ld1.addr);
    end
    if (ld0.vld)
    begin
      need0 = !ld_hit[0] && !line_pending(mv_d, ml_d, line_of(ld0.addr));
      if (!need0 || free)
      begin
        acc_d[0] = 1'b1;
        rd_en[bank_of(ld0.addr)] = 1'b1;
        rd_row[bank_of(ld0.addr)] = row_of(ld0.addr);
        bank_d[0] = bank_of(ld0.addr);
        if (need0)
        begin
          mv_d[slot] = 1'b1;
          ml_d[slot] = line_of(ld0.addr);
          mreq_d = '{vld: 1'b1, line: line_of(ld0.addr), pref: 1'b0};
        end
      end
    end
    if (acc_d[0] && ld1.vld && !conf)
    begin
      need1 = !ld_hit[1] && !line_pending(mv_d, ml_d, line_of(ld1.addr));
      if (!need1)
      begin
        acc_d[1] = 1'b1;
        rd_en[bank_of(ld1.addr)] = 1'b1;
        rd_row[bank_of(ld1.addr)] = row_of(ld1.addr);
        bank_d[1] = bank_of(ld1.addr);
      end
    end
    pf_blk = st.vld && line_of(st.addr) == line_of(pf.addr) && !st_done;
    if (pf.vld && !ld0.vld && !pf_blk)
    begin
      pf_need = !line_pending(mv_d, ml_d, line_of(pf.addr));
      if (!pf_need || free)
      begin
        pf_acc_d = 1'b1;
        if (pf_need)
        begin
          mv_d[slot] = 1'b1;
          ml_d[slot] = line_of(pf.addr);
          mreq_d = '{vld: 1'b1, line: line_of(pf.addr), pref: 1'b1};
        end
      end
    end
    conf_d = conf;
    mcnt_d = '0;
    for (int i = 0; i < ldc_pkg::N_MISS; i++)
    begin
      mcnt_d = mcnt_d + 4'(mv_d[i]);
    end
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      mv_q          <= '0;
      ml_q          <= '0;
      mem_req_q     <= '0;
      miss_cnt_q    <= '0;
      ld_acc_q      <= '0;
      ld_conflict_q <= 1'b0;
      pf_acc_q      <= 1'b0;
      bank_q        <= '0;
    end
    else
    begin
      mv_q          <= mv_d;
      ml_q          <= ml_d;
      mem_req_q     <= mreq_d;
      miss_cnt_q    <= mcnt_d;
      ld_acc_q      <= acc_d;
      ld_conflict_q <= conf_d;
      pf_acc_q      <= pf_acc_d;
      bank_q        <= bank_d;
    end
  end

  // A write outside the open region, or a flush, hands the buffer out.
  always_comb
  begin
    logic [5:0] off;
    off   = wr.addr[ldc_pkg::LINE_LSB-1:0];
    wcb_d = wcb_q;
    wco_d = '0;
    if (wc_flush && wcb_q.vld)
    begin
      wco_d = wcb_q;
      wcb_d = '0;
    end
    if (wr.vld)
    begin
      if (wcb_d.vld && wcb_d.line != line_of(wr.addr))
      begin
        wco_d = wcb_d;
        wcb_d = '0;
      end
      wcb_d.vld = 1'b1;
      wcb_d.line = line_of(wr.addr);
      wcb_d.be[off] = 1'b1;
      wcb_d.data[{off, 3'b000} +: 8] = wr_data;
    end
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wcb_q    <= '0;
      wc_out_q <= '0;
    end
    else
    begin
      wcb_q    <= wcb_d;
      wc_out_q <= wco_d;
    end
  end

endmodule

// ### ldc_ctrl_monitor.sv
// Checker bound to every load and miss controller.
// Assumes it sees the controller ports only.
`timescale 1ns/1ps
module ldc_ctrl_monitor (
  // Clock and reset.
  input wire logic              clock,
  input wire logic              arst_n,
  // Loads.
  input wire ldc_pkg::ldc_req_t ld0,
  input wire ldc_pkg::ldc_req_t ld1,
  input wire logic [1:0]        ld_hit,
  input wire logic [1:0]        ld_acc_q,
  input wire logic              ld_conflict_q,
  // Prefetch, store and memory.
  input wire ldc_pkg::ldc_req_t pf,
  input wire logic              pf_acc_q,
  input wire ldc_pkg::ldc_st_t  st,
  input wire logic              st_done,
  input wire ldc_pkg::ldc_mem_t mem_req_q,
  input wire logic              mem_fill,
  input wire logic [3:0]        miss_cnt_q
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  AST_CNT_MAX: assert property (miss_cnt_q <= 4'h8)
    else $error("miss count above eight");
  AST_FULL: assert property (miss_cnt_q == 4'h8 && !mem_fill |=> !mem_req_q.vld)
    else $error("line request while table full");
  AST_ORDER: assert property (ld_acc_q[1] |-> ld_acc_q[0])
    else $error("younger load without older");
  AST_CONF_ONE: assert property (ld_conflict_q |-> !ld_acc_q[1])
    else $error("two loads on conflict");
  AST_CONF_CAUSE: assert property (ld_conflict_q |-> $past(ld0.vld && ld1.vld
    && ld0.addr[6:4] == ld1.addr[6:4] && ld0.addr[11:7] != ld1.addr[11:7]))
    else $error("conflict without cause");
  AST_PAIR_OK: assert property (ld0.vld && ld1.vld && ld_hit == 2'b11
    && (ld0.addr[6:4] != ld1.addr[6:4] || ld0.addr[11:7] == ld1.addr[11:7])
    |=> ld_acc_q == 2'b11 && !ld_conflict_q)
    else $error("clean pair not dual issued");
  AST_PF_HOLD: assert property (pf_acc_q |-> $past(pf.vld && !ld0.vld
    && !(st.vld && !st_done && st.addr[39:6] == pf.addr[39:6])))
    else $error("prefetch taken past store");
  AST_PF_REQ: assert property (mem_req_q.pref |-> mem_req_q.vld && pf_acc_q)
    else $error("prefetch request without accept");
endmodule

bind ldc_ctrl ldc_ctrl_monitor u_mon (
  .clock, .arst_n, .ld0, .ld1, .ld_hit, .ld_acc_q, .ld_conflict_q, .pf, .pf_acc_q,
  .st, .st_done, .mem_req_q, .mem_fill, .miss_cnt_q
);

// ### ldc_mem_model.sv
// Lower memory model: queues line requests and fills them in order.
// Assumes one request pulse per new line; stall holds fills back.
`timescale 1ns/1ps
module ldc_mem_model (
  // Clock and reset.
  input  wire logic                   clock,
  input  wire logic                   arst_n,
  // Requests and pacing.
  input  wire ldc_pkg::ldc_mem_t      mem_req_q,
  input  wire logic                   stall,
  // Fill return.
  output logic                        mem_fill,
  output logic [ldc_pkg::LINE_W-1:0]  mem_fill_line,
  output logic [127:0]                mem_fill_data,
  output logic [ldc_pkg::N_BANKS-1:0] mem_fill_bank
);
  logic [ldc_pkg::LINE_W-1:0] pend[$];
  int                         gap;

  always @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pend.delete();
      gap <= 0;
      mem_fill <= 1'b0;
      mem_fill_line <= '0;
      mem_fill_data <= '0;
      mem_fill_bank <= '0;
    end
    else
    begin
      if (mem_req_q.vld === 1'b1)
        pend.push_back(mem_req_q.line);
      gap <= gap + 1;
      mem_fill <= 1'b0;
      // Idle fill line and data flip so a stale value is never mistaken for a fill; the bank mask holds.
      mem_fill_line <= ~mem_fill_line;
      mem_fill_data <= ~mem_fill_data;
      if (!stall && pend.size() > 0 && gap % 4 == 0)
      begin
        mem_fill <= 1'b1;
        mem_fill_line <= pend.pop_front();
        mem_fill_data <= {4{$urandom()}};
        mem_fill_bank <= 8'hff;
      end
    end
  end
endmodule

// ### ldc_ctrl_test.sv
// Bench for ldc_ctrl: load pairs, miss table, prefetch hold, write combining.
// Assumes the memory model on the fill side and the bound monitor.
`timescale 1ns/1ps
module ldc_ctrl_test;
  logic              clock = 1'b0;
  logic              arst_n = 1'b0;
  logic              stall = 1'b1;
  logic              st_done = 1'b0;
  logic              wc_flush = 1'b0;
  logic [1:0]        ld_hit = 2'b11;
  logic [7:0]        wr_data = 8'h00;
  ldc_pkg::ldc_req_t ld0 = '0;
  ldc_pkg::ldc_req_t ld1 = '0;
  ldc_pkg::ldc_req_t pf = '0;
  ldc_pkg::ldc_req_t wr = '0;
  ldc_pkg::ldc_st_t  st = '0;
  ldc_pkg::ldc_mem_t mem_req_q;
  ldc_pkg::ldc_wc_t  wc_out_q;
  logic [1:0][127:0] ld_data;
  logic [127:0]      rows[32];
  logic [127:0]      q_dat[$];
  logic [511:0]      wd[2] = '{512'h0, 512'h0};
  logic [511:0]      q_wd[$];
  logic [7:0]        d;
  logic [1:0]        ld_acc_q;
  logic              ld_conflict_q, pf_acc_q, mem_fill;
  logic [33:0]       mem_fill_line;
  logic [127:0]      mem_fill_data;
  logic [7:0]        mem_fill_bank, q_pf[$];
  logic [3:0]        miss_cnt_q;
  logic [2:0]        q_ld[$];
  logic [97:0]       q_wc[$];
  logic [39:0]       wa[4] = '{40'h300000, 40'h300005, 40'h30003f, 40'h300041};
  logic [39:0]       a, b;
  logic              c;
  int                n_fail = 0;
  int                compares = 0;
  int                n_req = 0;

  always #5 clock = ~clock;

  ldc_ctrl DUT (
    .clock, .arst_n, .ld0, .ld1, .ld_hit, .ld_acc_q, .ld_conflict_q, .ld_data,
    .pf, .pf_acc_q, .st, .st_done, .mem_req_q, .mem_fill, .mem_fill_line,
    .mem_fill_data, .mem_fill_bank, .miss_cnt_q, .wr, .wr_data, .wc_flush, .wc_out_q
  );
  ldc_mem_model u_mem (
    .clock, .arst_n, .mem_req_q, .stall, .mem_fill, .mem_fill_line,
    .mem_fill_data, .mem_fill_bank
  );

  task automatic cmp_ld(logic [2:0] e, logic [2:0] g);
    compares++;
    if (e !== g)
    begin
      n_fail++;
      $display("Error load accept expected %h seen %h", e, g);
    end
  endtask

  task automatic cmp_v(string n, logic [97:0] e, logic [97:0] g);
    compares++;
    if (e !== g)
    begin
      n_fail++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic cmp_d(string n, logic [511:0] e, logic [511:0] g);
    compares++;
    if (e !== g)
    begin
      n_fail++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic give_verdict();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic drive(logic [39:0] x, logic [39:0] y, logic v);
    @(posedge clock);
    ld0 <= '{1'b1, x};
    ld1 <= '{v, y};
    @(posedge clock);
    ld0 <= '0;
    ld1 <= '0;
  endtask

  // Bounded wait for a miss count, sampled where the outputs are settled.
  task automatic wt(logic [3:0] v);
    int k;
    // Step off the launching edge first, or the old count would be read.
    @(negedge clock);
    for (k = 0; k < 300 && miss_cnt_q !== v; k++)
      @(negedge clock);
    if (k == 300)
    begin
      n_fail++;
      give_verdict();
    end
    @(posedge clock);
  endtask

  always @(posedge clock)
  begin
    #1;
    if (mem_req_q.vld === 1'b1)
      n_req++;
    // Every fill writes its row in all banks, so the row alone predicts the read.
    if (mem_fill === 1'b1)
      rows[mem_fill_line[5:1]] = mem_fill_data;
    if (ld_acc_q !== 2'b00)
      cmp_ld(q_ld.size() ? q_ld.pop_front() : 3'h0, {ld_conflict_q, ld_acc_q});
    if (ld_acc_q[0] === 1'b1 && q_dat.size() > 0)
      cmp_d("load 0 data", 512'(q_dat.pop_front()), 512'(ld_data[0]));
    if (ld_acc_q[1] === 1'b1 && q_dat.size() > 0)
      cmp_d("load 1 data", 512'(q_dat.pop_front()), 512'(ld_data[1]));
    if (pf_acc_q !== 1'b0)
      cmp_v("prefetch", q_pf.size() ? q_pf.pop_front() : 8'h0, pf_acc_q);
    if (wc_out_q.vld !== 1'b0)
    begin
      cmp_v("wc", q_wc.size() ? q_wc.pop_front() : '0, {wc_out_q.line, wc_out_q.be});
      cmp_d("wc data", q_wd.size() ? q_wd.pop_front() : '0, wc_out_q.data);
    end
  end

  initial
  begin
    #400000;
    n_fail++;
    give_verdict();
  end

  initial
  begin
    repeat (8) @(posedge clock);
    arst_n <= 1'b1;
    void'($urandom(33561));
    for (int i = 0; i < 24; i++)
    begin
      a = 40'({$urandom(), $urandom()});
      b = 40'({$urandom(), $urandom()});
      if (i % 3 == 0)
        b[6:4] = a[6:4];
      if (i % 4 == 0)
        b[11:7] = a[11:7];
      c = a[6:4] == b[6:4] && a[11:7] != b[11:7];
      q_ld.push_back({c, ~c, 1'b1});
      drive(a, b, 1'b1);
      if (c)
      begin
        q_ld.push_back(3'h1);
        drive(b, a, 1'b0);
      end
    end
    ld_hit <= 2'b00;
    for (int i = 0; i < 8; i++)
    begin
      q_ld.push_back(3'h1);
      drive(40'h100000 + 40'(i * 64), '0, 1'b0);
    end
    q_ld.push_back(3'h1);
    drive(40'h1000c8, '0, 1'b0);
    drive(40'h100200, '0, 1'b0);
    @(negedge clock);
    cmp_v("miss count", 98'h8, miss_cnt_q);
    @(posedge clock);
    stall <= 1'b0;
    wt(4'h7);
    q_ld.push_back(3'h1);
    drive(40'h100200, '0, 1'b0);
    wt(4'h0);
    ld_hit <= 2'b11;
    q_ld.push_back(3'h3);
    q_dat.push_back(rows[0]);
    q_dat.push_back(rows[0]);
    drive(40'h100000, 40'h100010, 1'b1);
    q_ld.push_back(3'h5);
    q_dat.push_back(rows[1]);
    drive(40'h100080, 40'h100100, 1'b1);
    st <= '{1'b1, 40'h200010, 8'h5a};
    pf <= '{1'b1, 40'h200030};
    repeat (4) @(posedge clock);
    q_pf.push_back(8'h1);
    st_done <= 1'b1;
    @(posedge clock);
    st_done <= 1'b0;
    st <= '0;
    pf <= '0;
    wt(4'h0);
    q_wc.push_back({34'hc000, 64'h8000000000000021});
    q_wc.push_back({34'hc001, 64'h2});
    foreach (wa[i])
    begin
      d = 8'($urandom());
      wd[wa[i][6]][{wa[i][5:0], 3'b000} +: 8] = d;
      @(posedge clock);
      wr <= '{1'b1, wa[i]};
      wr_data <= d;
    end
    q_wd.push_back(wd[0]);
    q_wd.push_back(wd[1]);
    @(posedge clock);
    wr <= '0;
    wc_flush <= 1'b1;
    @(posedge clock);
    wc_flush <= 1'b0;
    repeat (4) @(posedge clock);
    cmp_v("requests", 98'ha, 98'(n_req));
    cmp_v("left", '0, 98'(q_ld.size() + q_pf.size() + q_wc.size() + q_dat.size() + q_wd.size()));
    give_verdict();
  end
endmodule
